// [phy_control_diag.sv]
// Control and diagnostic top: registers, interrupt, crossover, loopbacks
// Notes on behaviour
// - Upper interrupt byte enables eight conditions
// - Lower interrupt byte records occurred conditions
// - Reading interrupt register clears all status
// - Control bit 9 picks polarity; default low
// - Auto crossover on at reset; bit 13 disables
// - Bit 14 forces pair map when auto off
// - Auto mode follows partner's sensed pair usage
// - Local loopback returns MAC transmit, full duplex
// - Looped frames also hit line unless disabled
// - Basic control: loopback, speed, autoneg, duplex
// - Control bit 3 disables line transmitter
// - Remote loopback returns line frames, 100 full
// - Control bit 2 enables remote loopback
// - Writing start bit launches test, self clears
// - Start bit reads one while test runs
// - Result code: normal, open, short, failed
// - Unsilenced partner gives failed code, no measurement
// - Nine-bit fault distance in low bits
// - Pulse sent, reflection gives type and distance
module phy_control_diag
  import phy_ctrl_pkg::*;
#(
  parameter int DIAG_WINDOW = DIAG_WINDOW_CYC
)(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [7:0]  int_event_i,
  output logic             irq_out_o,
  input  wire logic        partner_mdix_i,
  output logic             mdix_sel_o,
  output logic [1:0]       link_speed_o,
  input  wire logic        mac_tx_en_i,
  input  wire logic [1:0]  mac_txd_i,
  output logic             mac_crs_dv_o,
  output logic [1:0]       mac_rxd_o,
  input  wire logic        line_rx_dv_i,
  input  wire logic [1:0]  line_rxd_i,
  output logic             line_tx_en_o,
  output logic [1:0]       line_txd_o,
  input  wire logic        link_up_i,
  input  wire logic        link_100_full_i,
  input  wire logic        partner_quiet_i,
  input  wire logic        echo_i,
  input  wire logic        echo_short_i,
  output logic             diag_pulse_o
);
  import phy_ctrl_pkg::*;

  logic        wr_stb, rd_stb;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data, rd_data;
  logic [15:0] bc_q, bc_d, pc2_q, pc2_d;
  logic [7:0]  ien_q, ien_d, ist_q, ist_d;
  logic [7:0]  ev_m_q, ev_s_q, ev_p_q;
  logic [2:0]  ana_m_q, ana_s_q;  // Quiet, echo, echo shape from the analog side
  logic        mdix_m_q, mdix_s_q;
  logic        start_q, start_d;
  logic        diag_busy;
  logic [1:0]  diag_res;
  logic [CD_DIST_W-1:0] diag_dist;
  logic        irq_act;
  logic        lb_local, lb_remote, tx_disable;
  logic        txen_q, rxdv_q;
  logic [1:0]  txd_q, rxd_q;
  logic        crs_q, crs_d, ltx_q, ltx_d;
  logic [1:0]  mrxd_q, mrxd_d, ltxd_q, ltxd_d;

  mdio_slave u_mdio (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .mdc_i      (mdc_i),
    .mdio_i     (mdio_i),
    .phy_addr_i (phy_addr_i),
    .rd_data_i  (rd_data),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o),
    .wr_stb_o   (wr_stb),
    .rd_stb_o   (rd_stb),
    .reg_addr_o (reg_addr),
    .wr_data_o  (wr_data)
  );

  cable_diag #(.WINDOW_CYC(DIAG_WINDOW)) u_diag (
    .ref_clk_i       (ref_clk_i),
    .nrst_i          (nrst_i),
    .start_i         (start_q),
    .partner_quiet_i (ana_s_q[2]),
    .echo_i          (ana_s_q[1]),
    .echo_short_i    (ana_s_q[0]),
    .busy_o          (diag_busy),
    .pulse_o         (diag_pulse_o),
    .result_o        (diag_res),
    .dist_o          (diag_dist)
  );

  // Read mux; returned value is the pre-clear status
  always_comb begin
    case (reg_addr)
      REG_BASIC_CONTROL:   rd_data = bc_q;
      REG_INT_CTRL_STATUS: rd_data = {ien_q, ist_q};
      REG_CABLE_DIAG:      rd_data = {diag_busy | start_q, diag_res, 4'h0, diag_dist};
      REG_PHY_CONTROL_SECOND:   rd_data = pc2_q;
      default:             rd_data = 16'h0000;
    endcase
  end

  // Event edges from outside domain; new events beat the read clear
  always_comb begin
    bc_d    = bc_q;
    pc2_d   = pc2_q;
    ien_d   = ien_q;
    start_d = 1'b0;
    ist_d   = ist_q;
    if (rd_stb && reg_addr == REG_INT_CTRL_STATUS) ist_d = 8'h00;
    ist_d = ist_d | (ev_s_q & ~ev_p_q);
    if (wr_stb) begin
      case (reg_addr)
        REG_BASIC_CONTROL:   bc_d  = wr_data;
        REG_INT_CTRL_STATUS: ien_d = wr_data[15:8];
        REG_PHY_CONTROL_SECOND:   pc2_d = wr_data;
        REG_CABLE_DIAG:      start_d = wr_data[CD_START_BIT] & ~diag_busy;
        default:             ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      bc_q <= BASIC_CONTROL_RST; pc2_q <= PHY_CONTROL_SECOND_RST;
      ien_q <= 8'h00; ist_q <= 8'h00; start_q <= 1'b0;
      ev_m_q <= '0; ev_s_q <= '0; ev_p_q <= '0; mdix_m_q <= 1'b0; mdix_s_q <= 1'b0;
      ana_m_q <= '0; ana_s_q <= '0;
    end else begin
      bc_q <= bc_d; pc2_q <= pc2_d; ien_q <= ien_d; ist_q <= ist_d; start_q <= start_d;
      ev_m_q <= int_event_i; ev_s_q <= ev_m_q; ev_p_q <= ev_s_q;
      mdix_m_q <= partner_mdix_i; mdix_s_q <= mdix_m_q;
      // Analog levels are asynchronous; two flops before the sequencer sees them
      ana_m_q <= {partner_quiet_i, echo_i, echo_short_i}; ana_s_q <= ana_m_q;
    end
  end

  // Interrupt pin level follows programmed polarity
  assign irq_act   = |(ien_q & ist_q);
  assign irq_out_o = pc2_q[PC2_IRQ_LEVEL_BIT] ? irq_act : ~irq_act;

  // Pair map: sensed in auto mode, else forced by software
  assign mdix_sel_o = pc2_q[PC2_MDIX_DIS_BIT] ? pc2_q[PC2_MDIX_SEL_BIT]
                                              : mdix_s_q;
  assign link_speed_o = {bc_q[BC_SPEED_BIT], bc_q[BC_DUPLEX_BIT]};

  // Loopback qualification; local needs full duplex, remote needs link up at 100 full
  assign lb_local   = bc_q[BC_LOOPBACK_BIT] & bc_q[BC_DUPLEX_BIT];
  assign lb_remote  = pc2_q[PC2_REMOTE_LB_BIT] & link_up_i & link_100_full_i;
  assign tx_disable = pc2_q[PC2_TX_DIS_BIT];

  // Datapath steering; two register stages each way, same reference clock
  always_comb begin
    crs_d  = rxdv_q;
    mrxd_d = rxdv_q ? rxd_q : 2'h0;
    ltx_d  = txen_q;
    ltxd_d = txen_q ? txd_q : 2'h0;
    if (lb_local) begin
      crs_d  = txen_q;
      mrxd_d = txen_q ? txd_q : 2'h0;
    end
    if (lb_remote) begin
      ltx_d  = rxdv_q;
      ltxd_d = rxdv_q ? rxd_q : 2'h0;
    end
    if (tx_disable) begin
      ltx_d  = 1'b0;
      ltxd_d = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      txen_q <= 1'b0; txd_q <= '0; rxdv_q <= 1'b0; rxd_q <= '0;
      crs_q <= 1'b0; mrxd_q <= '0; ltx_q <= 1'b0; ltxd_q <= '0;
    end else begin
      txen_q <= mac_tx_en_i; txd_q <= mac_txd_i; rxdv_q <= line_rx_dv_i; rxd_q <= line_rxd_i;
      crs_q <= crs_d; mrxd_q <= mrxd_d; ltx_q <= ltx_d; ltxd_q <= ltxd_d;
    end
  end

  assign mac_crs_dv_o = crs_q;
  assign mac_rxd_o    = mrxd_q;
  assign line_tx_en_o = ltx_q;
  assign line_txd_o   = ltxd_q;
  // Diagnostic pulse, echo timing and fail path live in cable_diag
endmodule : phy_control_diag

// [phy_ctrl_pkg.sv]
// Package: register map, field positions, reset values and timing counts
package phy_ctrl_pkg;
  localparam logic [4:0]  REG_BASIC_CONTROL   = 5'h00;
  localparam logic [4:0]  REG_INT_CTRL_STATUS = 5'h1b;
  localparam logic [4:0]  REG_CABLE_DIAG      = 5'h1d;
  localparam logic [4:0]  REG_PHY_CONTROL_SECOND   = 5'h1f;
  // Basic control fields
  localparam int BC_LOOPBACK_BIT = 14;
  localparam int BC_SPEED_BIT    = 13;
  localparam int BC_ANEG_BIT     = 12;
  localparam int BC_DUPLEX_BIT   = 8;
  // Second control fields
  localparam int PC2_MDIX_SEL_BIT   = 14;
  localparam int PC2_MDIX_DIS_BIT   = 13;
  localparam int PC2_IRQ_LEVEL_BIT  = 9;
  localparam int PC2_TX_DIS_BIT     = 3;
  localparam int PC2_REMOTE_LB_BIT  = 2;
  // Cable diagnostic fields
  localparam int CD_START_BIT  = 15;
  localparam int CD_RESULT_HI  = 14;
  localparam int CD_RESULT_LO  = 13;
  localparam int CD_DIST_W     = 9;
  localparam logic [1:0] CD_NORMAL = 2'h0;
  localparam logic [1:0] CD_OPEN   = 2'h1;
  localparam logic [1:0] CD_SHORT  = 2'h2;
  localparam logic [1:0] CD_FAIL   = 2'h3;
  // Reset values
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h3100;
  localparam logic [15:0] PHY_CONTROL_SECOND_RST = 16'h0000;
  // Management frame
  localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;
  localparam int         PREAMBLE_BITS    = 32;
  // Diagnostic timing
  localparam int DIAG_PULSE_NS   = 100;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int DIAG_PULSE_CYC  = (DIAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIAG_WINDOW_CYC = 1024;
endpackage : phy_ctrl_pkg

// [mdio_slave.sv]
// MII management serial slave running from sampled MDC edges
module mdio_slave
  import phy_ctrl_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [15:0] rd_data_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  output logic             wr_stb_o,
  output logic             rd_stb_o,
  output logic [4:0]       reg_addr_o,
  output logic [15:0]      wr_data_o
);
  import phy_ctrl_pkg::*;
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} mst_e;
  mst_e        st_q, st_d;
  logic [2:0]  mdc_s_q, mdc_s_d;
  logic [1:0]  mdio_s_q, mdio_s_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic        rd_q, rd_d, ours_q, ours_d, oe_q, oe_d, out_q, out_d;
  logic        wr_d, rs_d;
  logic [4:0]  ra_q, ra_d;
  logic [15:0] wd_d;
  logic        rise, fall, bit_in;

  // Two flops before use; third stage only feeds edge detection
  assign rise   = mdc_s_q[1] & ~mdc_s_q[2];
  assign fall   = ~mdc_s_q[1] & mdc_s_q[2];
  assign bit_in = mdio_s_q[1];

  // Frame decoder: preamble, start, opcode, addresses, turnaround, data
  always_comb begin
    mdc_s_d  = {mdc_s_q[1:0], mdc_i};
    mdio_s_d = {mdio_s_q[0], mdio_i};
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; rd_d = rd_q; ours_d = ours_q;
    oe_d = oe_q; out_d = out_q; ra_d = ra_q; wr_d = 1'b0; rs_d = 1'b0; wd_d = wr_data_o;
    // Shift only once data bits begin; both turnaround bits stay at zero
    if (fall && oe_q && st_q == S_DATA) begin
      out_d = sh_q[15];
      sh_d  = {sh_q[14:0], 1'b0};
    end
    if (rise) begin
      case (st_q)
        S_PRE: begin
          if (bit_in) cnt_d = (cnt_q == 6'd32) ? cnt_q : cnt_q + 6'd1;
          else if (cnt_q == 6'(PREAMBLE_BITS)) st_d = S_ST;
          else cnt_d = '0;
        end
        S_ST: begin
          st_d = bit_in ? S_HDR : S_PRE;
          cnt_d = '0;
        end
        S_HDR: begin
          sh_d  = {sh_q[14:0], bit_in};
          cnt_d = cnt_q + 6'd1;
          if (cnt_q == 6'd11) begin
            st_d   = S_TA;
            cnt_d  = '0;
            rd_d   = sh_q[10];
            ours_d = (sh_q[8:4] == phy_addr_i) || (sh_q[8:4] == PHY_ADDR_DEFAULT);
            ra_d   = {sh_q[3:0], bit_in};
            if (sh_q[10] && ((sh_q[8:4] == phy_addr_i) || (sh_q[8:4] == PHY_ADDR_DEFAULT))) begin
              oe_d = 1'b1;  // Drive zero through the turnaround
              out_d = 1'b0;
            end
          end
        end
        S_TA: begin
          cnt_d = cnt_q + 6'd1;
          // Fetch once the register address is registered, else the old one is read
          if (cnt_q == 6'd0 && rd_q && ours_q) begin
            rs_d = 1'b1;  // Read side effects happen here
            sh_d = rd_data_i;
          end
          if (cnt_q == 6'd1) begin
            st_d = S_DATA;
            cnt_d = '0;
          end
        end
        S_DATA: begin
          if (!rd_q) sh_d = {sh_q[14:0], bit_in};
          cnt_d = cnt_q + 6'd1;
          if (cnt_q == 6'd15) begin
            st_d = S_PRE;
            cnt_d = '0;
            oe_d = 1'b0;
            if (!rd_q && ours_q) begin
              wr_d = 1'b1;
              wd_d = {sh_q[14:0], bit_in};
            end
          end
        end
        default: st_d = S_PRE;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_q <= S_PRE; mdc_s_q <= '0; mdio_s_q <= 2'h3; cnt_q <= '0; sh_q <= '0;
      rd_q <= 1'b0; ours_q <= 1'b0; oe_q <= 1'b0; out_q <= 1'b0; ra_q <= '0;
      wr_stb_o <= 1'b0; rd_stb_o <= 1'b0; wr_data_o <= '0;
    end else begin
      st_q <= st_d; mdc_s_q <= mdc_s_d; mdio_s_q <= mdio_s_d; cnt_q <= cnt_d; sh_q <= sh_d;
      rd_q <= rd_d; ours_q <= ours_d; oe_q <= oe_d; out_q <= out_d; ra_q <= ra_d;
      wr_stb_o <= wr_d; rd_stb_o <= rs_d; wr_data_o <= wd_d;
    end
  end

  assign mdio_o     = out_q;
  assign mdio_oe_o  = oe_q;
  assign reg_addr_o = ra_q;
endmodule : mdio_slave

// [cable_diag.sv]
// Cable reflectometry sequencer: quiet check, pulse, echo timing
module cable_diag
  import phy_ctrl_pkg::*;
#(
  parameter int WINDOW_CYC = DIAG_WINDOW_CYC
)(
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                start_i,
  input  wire logic                partner_quiet_i,
  input  wire logic                echo_i,
  input  wire logic                echo_short_i,
  output logic                     busy_o,
  output logic                     pulse_o,
  output logic [1:0]               result_o,
  output logic [CD_DIST_W-1:0]     dist_o
);
  import phy_ctrl_pkg::*;
  // Counter is 16 bits wide; refuse windows it cannot count
  if (WINDOW_CYC < 2 || WINDOW_CYC > 65535) begin : g_bad_window
    $error("bad WINDOW_CYC");
  end
  typedef enum logic [1:0] {D_IDLE, D_PULSE, D_LISTEN} dst_e;
  dst_e                 st_q, st_d;
  logic [15:0]          cnt_q, cnt_d;
  logic [1:0]           res_q, res_d;
  logic [CD_DIST_W-1:0] dist_q, dist_d;

  // Reported echo distance saturates at the field width
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; res_d = res_q; dist_d = dist_q;
    case (st_q)
      D_IDLE: if (start_i) begin
        cnt_d = '0;
        if (!partner_quiet_i) begin
          res_d  = CD_FAIL;
          dist_d = '0;
        end else st_d = D_PULSE;
      end
      D_PULSE: begin
        cnt_d = cnt_q + 16'd1;
        if (cnt_q == 16'(DIAG_PULSE_CYC - 1)) begin
          st_d = D_LISTEN;
          cnt_d = '0;
        end
      end
      D_LISTEN: begin
        cnt_d = cnt_q + 16'd1;
        if (echo_i) begin  // Shape gives type, time gives distance
          st_d   = D_IDLE;
          res_d  = echo_short_i ? CD_SHORT : CD_OPEN;
          dist_d = (cnt_q > 16'h01ff) ? 9'h1ff : cnt_q[CD_DIST_W-1:0];
        end else if (cnt_q == 16'(WINDOW_CYC - 1)) begin
          st_d   = D_IDLE;
          res_d  = CD_NORMAL;
          dist_d = '0;
        end
      end
      default: st_d = D_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_q <= D_IDLE; cnt_q <= '0; res_q <= CD_NORMAL; dist_q <= '0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; res_q <= res_d; dist_q <= dist_d;
    end
  end

  assign busy_o   = (st_q != D_IDLE);
  assign pulse_o  = (st_q == D_PULSE);
  assign result_o = res_q;
  assign dist_o   = dist_q;
endmodule : cable_diag

// [phy_control_diag_assertions.sv]
// Port checker for the control and diagnostic block
module phy_control_diag_assertions
  import phy_ctrl_pkg::*;
#(
  parameter int DIAG_WINDOW = DIAG_WINDOW_CYC
)(
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       mdio_oe_o,
  input wire logic       irq_out_o,
  input wire logic [1:0] link_speed_o,
  input wire logic       mac_tx_en_i,
  input wire logic [1:0] mac_txd_i,
  input wire logic       mac_crs_dv_o,
  input wire logic [1:0] mac_rxd_o,
  input wire logic       line_rx_dv_i,
  input wire logic       line_tx_en_o,
  input wire logic [1:0] line_txd_o,
  input wire logic       link_up_i,
  input wire logic       link_100_full_i,
  input wire logic       partner_quiet_i,
  input wire logic       diag_pulse_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  localparam logic [15:0] PULSE_LEN = 16'(DIAG_PULSE_CYC);
  logic [15:0] pulse_cnt_q;
  logic [15:0] pulse_cnt_d;
  // Pulse length counter; zero between pulses so each pulse is judged alone
  always_comb begin
    pulse_cnt_d = diag_pulse_o ? pulse_cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk_i) begin
    pulse_cnt_q <= nrst_i ? pulse_cnt_d : 16'h0000;
  end
  sequence s_pulse_end;
    $fell(diag_pulse_o);
  endsequence
  // Reset values seen on the pins; no disable, reset is the cause here
  property p_rst_irq;
    !nrst_i |=> irq_out_o && !mdio_oe_o;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq or mdio drive wrong after reset");
  property p_rst_speed;
    !nrst_i |=> link_speed_o == 2'h3;
  endproperty
  a_rst_speed: assert property (p_rst_speed) else $error("speed/duplex reset wrong");
  // Two-cycle datapaths: output only from a source seen two cycles before
  property p_mac_src;
    disable iff (!nrst_i) mac_crs_dv_o |-> $past(mac_tx_en_i, 2) || $past(line_rx_dv_i, 2);
  endproperty
  a_mac_src: assert property (p_mac_src) else $error("mac receive without source");
  property p_mac_data;
    disable iff (!nrst_i) mac_crs_dv_o && $past(mac_tx_en_i, 2) && !$past(line_rx_dv_i, 2)
      |-> mac_rxd_o == $past(mac_txd_i, 2);
  endproperty
  a_mac_data: assert property (p_mac_data) else $error("looped dibit wrong");
  property p_line_src;
    disable iff (!nrst_i) line_tx_en_o |-> $past(mac_tx_en_i, 2)
      || ($past(line_rx_dv_i, 2) && $past(link_100_full_i, 2) && $past(link_up_i, 2));
  endproperty
  a_line_src: assert property (p_line_src) else $error("line transmit without source");
  property p_line_data;
    disable iff (!nrst_i) line_tx_en_o && $past(mac_tx_en_i, 2) |-> line_txd_o == $past(mac_txd_i, 2);
  endproperty
  a_line_data: assert property (p_line_data) else $error("line dibit wrong");
  property p_pulse_quiet;
    disable iff (!nrst_i) $rose(diag_pulse_o) |-> $past(partner_quiet_i);
  endproperty
  a_pulse_quiet: assert property (p_pulse_quiet) else $error("pulse while partner active");
  property p_pulse_len;
    disable iff (!nrst_i) s_pulse_end |-> pulse_cnt_q == PULSE_LEN;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
endmodule : phy_control_diag_assertions

bind phy_control_diag phy_control_diag_assertions #(.DIAG_WINDOW(DIAG_WINDOW))
  phy_control_diag_assertions_inst (.*);

// [mdio_master_model.sv]
// Management controller model: clocks and shifts management frames
module mdio_master_model (
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o,
  input  wire logic mdio_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // MDC rests low between frames; data moves after falling edges
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'h1, rd, !rd, pa, ra, 2'h2, wd};
    q = 16'h0000;
    #1;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe_o = !(rd && i < 18); // Line released for turnaround and read data
      mdio_o = f[i];
      #40 mdc_o = 1'b1;
      if (i < 16) q[i] = mdio_i;
      #40 mdc_o = 1'b0;
    end
    mdio_oe_o = 1'b0;
  endtask : frame
endmodule : mdio_master_model

// [phy_control_diag_bench.sv]
// Self-checking bench for the control and diagnostic block
module phy_control_diag_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_ctrl_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
  logic       ref_clk_i, nrst_i, mdc_i, mdio_i, mdio_o, mdio_oe_o, ms_out, ms_oe;
  logic       irq_out_o, partner_mdix_i, mdix_sel_o, mac_tx_en_i, mac_crs_dv_o;
  logic       line_rx_dv_i, line_tx_en_o, link_up_i, link_100_full_i, partner_quiet_i;
  logic       echo_i, echo_short_i, diag_pulse_o;
  logic [1:0] link_speed_o, mac_txd_i, mac_rxd_o, line_rxd_i, line_txd_o;
  logic [4:0] phy_addr_i;
  logic [7:0] int_event_i;
  int         err_count, total_checks, cycles;
  // Open-drain style line with pull-up when nobody drives
  assign mdio_i = mdio_oe_o ? mdio_o : (ms_oe ? ms_out : 1'b1);
  phy_control_diag #(.DIAG_WINDOW(2048)) phy_control_diag_inst (.*);
  mdio_master_model mdio_master_model_inst (.mdc_o(mdc_i), .mdio_o(ms_out),
    .mdio_oe_o(ms_oe), .mdio_i(mdio_i));
  always #2 ref_clk_i = ~ref_clk_i;
  // Hang guard, well above the expected run length
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] pa = 5'h03);
    logic [15:0] q;
    mdio_master_model_inst.frame(1'b0, pa, ra, d, q);
    cyc(4);
  endtask : wr
  task automatic rd(input logic [4:0] ra, output logic [15:0] q);
    mdio_master_model_inst.frame(1'b1, 5'h03, ra, 16'h0000, q);
    cyc(4);
  endtask : rd
  task automatic ev(input logic [7:0] v);
    int_event_i = v;
    cyc(4);
    int_event_i = 8'h00;
    cyc(4);
  endtask : ev
  // Eight steps: four dibits in, output compared two cycles after input
  task automatic burst(input logic src, input logic emac, input logic eline);
    logic       dv;
    logic [1:0] d;
    for (int i = 0; i < 8; i++) begin
      dv = (i >= 2) && (i < 6);
      d = dv ? 2'(i + 1) : 2'h0;
      if (!src) `CHK({mac_crs_dv_o, mac_rxd_o}, {dv & emac, d & {2{emac}}})
      `CHK({line_tx_en_o, line_txd_o}, {dv & eline, d & {2{eline}}})
      {mac_tx_en_i, line_rx_dv_i} = {!src && i < 4, src && i < 4};
      {mac_txd_i, line_rxd_i} = {2{(i < 4) ? 2'(i + 3) : 2'h0}};
      cyc(1);
    end
  endtask : burst
  task automatic t_reset();
    logic [15:0] q;
    rd(REG_BASIC_CONTROL, q);
    `CHK(q, BASIC_CONTROL_RST)
    rd(REG_PHY_CONTROL_SECOND, q);
    `CHK(q, PHY_CONTROL_SECOND_RST)
    rd(REG_CABLE_DIAG, q);
    `CHK(q, 16'h0000)
    rd(5'h05, q);
    `CHK(q, 16'h0000)
    `CHK({irq_out_o, link_speed_o}, 3'h7)
    $display("done reset");
  endtask : t_reset
  task automatic t_irq();
    logic [15:0] q;
    wr(REG_INT_CTRL_STATUS, 16'h0100);
    ev(8'h02);
    `CHK(irq_out_o, 1'b1)
    ev(8'h01);
    `CHK(irq_out_o, 1'b0)
    rd(REG_INT_CTRL_STATUS, q);
    `CHK(q, 16'h0103)
    `CHK(irq_out_o, 1'b1)
    rd(REG_INT_CTRL_STATUS, q);
    `CHK(q, 16'h0100)
    wr(REG_PHY_CONTROL_SECOND, 16'h0200);
    `CHK(irq_out_o, 1'b0)
    ev(8'h01);
    `CHK(irq_out_o, 1'b1)
    wr(REG_PHY_CONTROL_SECOND, 16'h0000);
    rd(REG_INT_CTRL_STATUS, q);
    $display("done irq");
  endtask : t_irq
  task automatic t_mdix();
    logic       a;
    logic [15:0] q;
    cyc(10);
    a = mdix_sel_o;
    partner_mdix_i = 1'b1;
    cyc(10);
    `CHK(mdix_sel_o, ~a)
    wr(REG_PHY_CONTROL_SECOND, 16'h6000);
    partner_mdix_i = 1'b0;
    cyc(10);
    `CHK(mdix_sel_o, 1'b1)
    wr(REG_PHY_CONTROL_SECOND, 16'h2000);
    wr(REG_PHY_CONTROL_SECOND, 16'h4000, 5'h07);
    `CHK(mdix_sel_o, 1'b0)
    rd(REG_PHY_CONTROL_SECOND, q);
    `CHK(q, 16'h2000)
    $display("done mdix");
  endtask : t_mdix
  task automatic t_loop();
    wr(REG_BASIC_CONTROL, 16'h4100);
    `CHK(link_speed_o, 2'h1)
    burst(1'b0, 1'b1, 1'b1);
    wr(REG_BASIC_CONTROL, 16'h6100);
    wr(REG_PHY_CONTROL_SECOND, 16'h0008);
    burst(1'b0, 1'b1, 1'b0);
    wr(REG_PHY_CONTROL_SECOND, 16'h0000);
    burst(1'b0, 1'b1, 1'b1);
    wr(REG_BASIC_CONTROL, 16'h4000);
    burst(1'b0, 1'b0, 1'b1);
    link_up_i = 1'b1;
    link_100_full_i = 1'b1;
    wr(REG_BASIC_CONTROL, 16'h2100);
    wr(REG_PHY_CONTROL_SECOND, 16'h0004);
    burst(1'b1, 1'b0, 1'b1);
    link_100_full_i = 1'b0;
    burst(1'b1, 1'b0, 1'b0);
    link_100_full_i = 1'b1;
    wr(REG_PHY_CONTROL_SECOND, 16'h0000);
    burst(1'b1, 1'b0, 1'b0);
    $display("done loopback");
  endtask : t_loop
  task automatic t_diag(input logic qt, input logic ec, input logic sh, input logic [1:0] res);
    logic [15:0] q;
    int          k;
    partner_quiet_i = qt;
    echo_short_i = sh;
    wr(REG_PHY_CONTROL_SECOND, 16'h2000);
    wr(REG_CABLE_DIAG, 16'h8000);
    for (k = 0; k < 100 && diag_pulse_o !== 1'b0; k++) cyc(1);
    cyc(20);
    `CHK(diag_pulse_o, 1'b0)
    echo_i = ec;
    rd(REG_CABLE_DIAG, q);
    `CHK(q[15], qt & ~ec)
    for (k = 0; k < 4 && q[15] !== 1'b0; k++) rd(REG_CABLE_DIAG, q);
    `CHK(q[15], 1'b0)
    `CHK(q[14:13], res)
    if (ec) `CHK(q[8:0] >= 9'h015 && q[8:0] <= 9'h017, 1'b1)
    else `CHK(q[8:0], 9'h000)
    echo_i = 1'b0;
    $display("done diag %0h", res);
  endtask : t_diag
  initial begin
    {ref_clk_i, nrst_i, partner_mdix_i, mac_tx_en_i, line_rx_dv_i} = 5'h00;
    {link_up_i, link_100_full_i, echo_i, echo_short_i, partner_quiet_i} = 5'h01;
    {mac_txd_i, line_rxd_i, int_event_i, phy_addr_i} = {12'h000, 5'h03};
    {err_count, total_checks, cycles} = 0;
    cyc(3);
    nrst_i = 1'b1;
    t_reset();
    t_irq();
    t_mdix();
    t_loop();
    t_diag(1'b1, 1'b1, 1'b0, CD_OPEN);
    t_diag(1'b1, 1'b1, 1'b1, CD_SHORT);
    t_diag(1'b1, 1'b0, 1'b0, CD_NORMAL);
    t_diag(1'b0, 1'b0, 1'b0, CD_FAIL);
    end_of_test();
  end
endmodule : phy_control_diag_bench
